// [sci_ch1_regs.sv]
`timescale 1ns/100ps
// Behaviour
// [RULE_01] overrun flag: set by hardware, write 1 clears, write 0 ignored, reset 0
// [RULE_02] receive trigger reads run status; write 1 arms reception; reset 0
// [RULE_03] receive enable is a plain read/write bit, reset 0
// [RULE_04] transmit trigger reads run status; write 1 starts sending; reset 0
// [RULE_05] transmit enable is a plain read/write bit, reset 0
// [RULE_06] data register: read gives received byte, write gives transmit byte
// [RULE_07] infrared output invert flips the encoded serial output when set
// [RULE_08] infrared input invert flips the incoming serial line when set
// [RULE_09] infrared enable selects infrared encoding, else normal serial
// [RULE_10] stop-bit select: 1 means two stop bits, 0 means one
// [RULE_11] bit-order select: 1 means MSB first, 0 means LSB first
// [RULE_12] each channel has a two-bit priority field, level 0 to 3, reset 0
// [RULE_13] channel 0 priority sits in bits 5:4 of priority register A
// [RULE_14] three interrupt enable bits per channel, all reset 0
// [RULE_15] three factor flags per channel, set by events, write 1 clears
// [RULE_16] serial enable hands four port pins to the serial functions
// [RULE_17] software loads the data register before triggering a transmission
// [RULE_18] async reception done while not re-armed sets the overrun flag
// [RULE_19] channel request while any factor flag and its enable are both 1
module sci_ch1_regs #(
  parameter int ADDR_W = 18
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ch1_async_mode,
  input wire logic ch1_rx_done,
  input wire logic [7:0] ch1_rx_byte,
  input wire logic ch1_tx_done,
  input wire logic ch1_line_error,
  input wire logic ch0_rx_done,
  input wire logic ch0_tx_done,
  input wire logic ch0_line_error,
  output logic [7:0] ch1_tx_byte,
  output logic ch1_tx_start,
  output logic ch1_rx_start,
  output logic ch1_receive_enable,
  output logic ch1_transmit_enable,
  output logic ch1_receive_trigger,
  output logic ch1_transmit_trigger,
  output logic ch1_stop_bit_select,
  output logic ch1_bit_order_select,
  output logic ch1_infrared_enable,
  output logic serial_pin_function_enable,
  output logic [1:0] ch0_irq_level,
  output logic [1:0] ch1_irq_level,
  output logic ch0_irq_req,
  output logic ch1_irq_req,
  output logic irq,
  input wire logic [3:0] ser_out,
  input wire logic [3:0] ser_oe,
  output logic [3:0] ser_in,
  input wire logic [3:0] port_out,
  input wire logic [3:0] port_oe,
  output logic [3:0] port_in,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic sci_pkg::sci_reg_type sci_decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[17:2];
    if (addr[1:0] != 2'h0) begin
      sci_decode = sci_pkg::REG_NONE;
    end else if (idx == sci_pkg::IDX_PRIO_A) begin
      sci_decode = sci_pkg::REG_PRIO_A;
    end else if (idx == sci_pkg::IDX_PRIO_B) begin
      sci_decode = sci_pkg::REG_PRIO_B;
    end else if (idx == sci_pkg::IDX_IRQ_EN) begin
      sci_decode = sci_pkg::REG_IRQ_EN;
    end else if (idx == sci_pkg::IDX_IRQ_FLAG) begin
      sci_decode = sci_pkg::REG_IRQ_FLAG;
    end else if (idx == sci_pkg::IDX_CH1_MODE) begin
      sci_decode = sci_pkg::REG_CH1_MODE;
    end else if (idx == sci_pkg::IDX_CH1_CTRL) begin
      sci_decode = sci_pkg::REG_CH1_CTRL;
    end else if (idx == sci_pkg::IDX_CH1_DATA) begin
      sci_decode = sci_pkg::REG_CH1_DATA;
    end else if (idx == sci_pkg::IDX_CH1_LINE) begin
      sci_decode = sci_pkg::REG_CH1_LINE;
    end else if (idx == sci_pkg::IDX_EVT_STATUS) begin
      sci_decode = sci_pkg::REG_EVT_STATUS;
    end else if (idx == sci_pkg::IDX_EVT_MASK) begin
      sci_decode = sci_pkg::REG_EVT_MASK;
    end else begin
      sci_decode = sci_pkg::REG_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  sci_pkg::sci_reg_type wr_sel;
  sci_pkg::sci_reg_type rd_sel;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_byte;
  logic [7:0] next_rdata;
  logic wr_lane;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_fire;
  assign wr_sel = sci_decode(s_axi_awaddr);
  assign rd_sel = sci_decode(s_axi_araddr);
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_lane = wr_fire && s_axi_wstrb[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sci_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == sci_pkg::REG_NONE) ? sci_pkg::RESP_SLVERR : sci_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] prio_a;
  logic [7:0] prio_b;
  logic [7:0] irq_enable;
  logic [7:0] line_opts;
  logic [sci_pkg::EVT_W-1:0] evt_mask;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prio_a <= sci_pkg::RST_BYTE;
      prio_b <= sci_pkg::RST_BYTE;
      irq_enable <= sci_pkg::RST_BYTE;
      line_opts <= sci_pkg::RST_BYTE;
      serial_pin_function_enable <= 1'b0;
      evt_mask <= '0;
    end else if (wr_lane) begin
      if (wr_sel == sci_pkg::REG_PRIO_A) begin
        prio_a <= wr_byte & sci_pkg::PRIO_A_MASK; // RULE_12 RULE_13
      end else if (wr_sel == sci_pkg::REG_PRIO_B) begin
        prio_b <= wr_byte & sci_pkg::PRIO_B_MASK; // RULE_12
      end else if (wr_sel == sci_pkg::REG_IRQ_EN) begin
        irq_enable <= wr_byte & sci_pkg::PRIO_B_MASK; // RULE_14
      end else if (wr_sel == sci_pkg::REG_CH1_LINE) begin
        line_opts <= wr_byte & sci_pkg::LINE_MASK; // RULE_07 RULE_08 RULE_09 RULE_10 RULE_11
      end else if (wr_sel == sci_pkg::REG_CH1_MODE) begin
        serial_pin_function_enable <= wr_byte[sci_pkg::MODE_PIN_EN]; // RULE_16
      end else if (wr_sel == sci_pkg::REG_EVT_MASK) begin
        evt_mask <= wr_byte[sci_pkg::EVT_W-1:0];
      end
    end
  end

  assign ch1_infrared_enable = line_opts[sci_pkg::LINE_IR_EN]; // RULE_09
  assign ch1_stop_bit_select = line_opts[sci_pkg::LINE_STOP]; // RULE_10
  assign ch1_bit_order_select = line_opts[sci_pkg::LINE_ORDER]; // RULE_11
  assign ch0_irq_level = prio_a[sci_pkg::PRIO_CH0_LSB +: 2]; // RULE_13
  assign ch1_irq_level = prio_b[sci_pkg::PRIO_CH1_LSB +: 2]; // RULE_12

  // ----------------------------------------------------------------
  // channel 1 transfer control
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic overrun;
  logic [7:0] rx_buffer;

  assign ctrl_wr = wr_lane && (wr_sel == sci_pkg::REG_CH1_CTRL);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch1_receive_enable <= 1'b0;
      ch1_transmit_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ch1_receive_enable <= wr_byte[sci_pkg::CTRL_RXEN]; // RULE_03
      ch1_transmit_enable <= wr_byte[sci_pkg::CTRL_TXEN]; // RULE_05
    end
  end

  // a fresh trigger write wins over a completion in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch1_transmit_trigger <= 1'b0;
      ch1_tx_start <= 1'b0;
    end else begin
      ch1_tx_start <= ctrl_wr && wr_byte[sci_pkg::CTRL_TXTRG] && ch1_transmit_enable; // RULE_04
      if (ctrl_wr && wr_byte[sci_pkg::CTRL_TXTRG] && ch1_transmit_enable) begin
        ch1_transmit_trigger <= 1'b1; // RULE_04 RULE_17
      end else if (ch1_tx_done || !ch1_transmit_enable) begin
        ch1_transmit_trigger <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch1_receive_trigger <= 1'b0;
      ch1_rx_start <= 1'b0;
    end else begin
      ch1_rx_start <= ctrl_wr && wr_byte[sci_pkg::CTRL_RXTRG] && ch1_receive_enable; // RULE_02
      if (ctrl_wr && wr_byte[sci_pkg::CTRL_RXTRG] && ch1_receive_enable) begin
        ch1_receive_trigger <= 1'b1; // RULE_02
      end else if (ch1_rx_done || !ch1_receive_enable) begin
        ch1_receive_trigger <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overrun <= 1'b0;
    end else if (ch1_rx_done && ch1_async_mode && !ch1_receive_trigger) begin
      overrun <= 1'b1; // RULE_18
    end else if (ctrl_wr && wr_byte[sci_pkg::CTRL_OVR]) begin
      overrun <= 1'b0; // RULE_01
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_buffer <= sci_pkg::RST_BYTE;
      ch1_tx_byte <= sci_pkg::RST_BYTE;
    end else begin
      if (ch1_rx_done) begin
        rx_buffer <= ch1_rx_byte; // RULE_06
      end
      if (wr_lane && wr_sel == sci_pkg::REG_CH1_DATA) begin
        ch1_tx_byte <= wr_byte; // RULE_06
      end
    end
  end

  // ----------------------------------------------------------------
  // factor flags, channel requests and event status
  // ----------------------------------------------------------------
  logic [sci_pkg::FLAG_W-1:0] flag_set;
  logic [sci_pkg::FLAG_W-1:0] flag_clear;
  logic [sci_pkg::FLAG_W-1:0] flags;
  logic [sci_pkg::FLAG_W-1:0] flag_active;
  logic [sci_pkg::EVT_W-1:0] evt_set;
  logic [sci_pkg::EVT_W-1:0] evt_clear;
  logic [sci_pkg::EVT_W-1:0] evt_status;
  logic ch1_overrun_event;

  assign ch1_overrun_event = ch1_rx_done && ch1_async_mode && !ch1_receive_trigger;

  always_comb begin
    flag_set = '0;
    flag_set[sci_pkg::FLAG_ERR1] = ch1_line_error || ch1_overrun_event; // RULE_15
    flag_set[sci_pkg::FLAG_REC1] = ch1_rx_done;
    flag_set[sci_pkg::FLAG_TRA1] = ch1_tx_done;
    flag_set[sci_pkg::FLAG_ERR0] = ch0_line_error;
    flag_set[sci_pkg::FLAG_REC0] = ch0_rx_done;
    flag_set[sci_pkg::FLAG_TRA0] = ch0_tx_done;
  end

  assign flag_clear = (wr_lane && wr_sel == sci_pkg::REG_IRQ_FLAG) ?
                      wr_byte[sci_pkg::FLAG_W-1:0] : '0; // RULE_15

  sci_sticky_flags #(
    .W(sci_pkg::FLAG_W)
  ) u_factor_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .set(flag_set),
    .clear(flag_clear),
    .flags(flags)
  );

  assign flag_active = flags & irq_enable[sci_pkg::FLAG_W-1:0]; // RULE_14
  assign ch1_irq_req = |flag_active[sci_pkg::FLAG_ERR1:sci_pkg::FLAG_TRA1]; // RULE_19
  assign ch0_irq_req = |flag_active[sci_pkg::FLAG_ERR0:sci_pkg::FLAG_TRA0]; // RULE_19

  always_comb begin
    evt_set = '0;
    evt_set[sci_pkg::EVT_OVR] = ch1_overrun_event;
    evt_set[sci_pkg::EVT_RX] = ch1_rx_done;
    evt_set[sci_pkg::EVT_TX] = ch1_tx_done;
  end

  assign evt_clear = (rd_fire && rd_sel == sci_pkg::REG_EVT_STATUS) ? '1 : '0;

  sci_sticky_flags #(
    .W(sci_pkg::EVT_W)
  ) u_event_status (
    .clk(clk),
    .sys_rst(sys_rst),
    .set(evt_set),
    .clear(evt_clear),
    .flags(evt_status)
  );

  assign irq = |(evt_status & evt_mask);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    case (rd_sel)
      sci_pkg::REG_PRIO_A: next_rdata = prio_a;
      sci_pkg::REG_PRIO_B: next_rdata = prio_b;
      sci_pkg::REG_IRQ_EN: next_rdata = irq_enable;
      sci_pkg::REG_IRQ_FLAG: next_rdata = {2'h0, flags};
      sci_pkg::REG_CH1_MODE: next_rdata = {7'h00, serial_pin_function_enable};
      sci_pkg::REG_CH1_CTRL: next_rdata = {3'h0, overrun, ch1_receive_trigger,
                                           ch1_receive_enable, ch1_transmit_trigger,
                                           ch1_transmit_enable}; // RULE_01 RULE_02 RULE_04
      sci_pkg::REG_CH1_DATA: next_rdata = rx_buffer;
      sci_pkg::REG_CH1_LINE: next_rdata = line_opts;
      sci_pkg::REG_EVT_STATUS: next_rdata = {5'h00, evt_status};
      sci_pkg::REG_EVT_MASK: next_rdata = {5'h00, evt_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sci_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, next_rdata};
      s_axi_rresp <= (rd_sel == sci_pkg::REG_NONE) ? sci_pkg::RESP_SLVERR : sci_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin function and infrared line handling
  // ----------------------------------------------------------------
  sci_line_io u_line_io (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_function_enable(serial_pin_function_enable),
    .infrared_enable(ch1_infrared_enable),
    .input_invert(line_opts[sci_pkg::LINE_IN_INV]),
    .output_invert(line_opts[sci_pkg::LINE_OUT_INV]),
    .ser_out(ser_out),
    .ser_oe(ser_oe),
    .ser_in(ser_in),
    .port_out(port_out),
    .port_oe(port_oe),
    .port_in(port_in),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_overrun_set: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
    ch1_rx_done && ch1_async_mode && !ch1_receive_trigger |=> overrun && flags[sci_pkg::FLAG_ERR1])
    else $error("overrun not raised");
  a_overrun_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    ctrl_wr && wr_byte[sci_pkg::CTRL_OVR] && !ch1_overrun_event |=> !overrun)
    else $error("overrun not cleared");
  a_tx_trigger_run: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    ctrl_wr && wr_byte[sci_pkg::CTRL_TXTRG] && ch1_transmit_enable
    |=> ch1_transmit_trigger && ch1_tx_start ##1 !ch1_tx_start)
    else $error("transmit start wrong");
  a_tx_trigger_stop: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    ch1_tx_done && !(ctrl_wr && wr_byte[sci_pkg::CTRL_TXTRG]) |=> !ch1_transmit_trigger)
    else $error("transmit status stuck");
  a_rx_trigger_run: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    ctrl_wr && wr_byte[sci_pkg::CTRL_RXTRG] && ch1_receive_enable |=> ch1_receive_trigger)
    else $error("receive trigger not set");
  a_rx_data_load: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    ch1_rx_done |=> rx_buffer == $past(ch1_rx_byte))
    else $error("receive byte not held");
  a_factor_set: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    ch1_rx_done |=> flags[sci_pkg::FLAG_REC1] ##1 flags[sci_pkg::FLAG_REC1] || $past(wr_lane))
    else $error("receive factor lost");
  a_irq_request: assert property (@(posedge clk) disable iff (sys_rst) // RULE_19
    ch1_irq_req == |(flags[5:3] & irq_enable[5:3]))
    else $error("channel request mismatch");
  a_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
    rd_fire |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read answer late");
  c_overrun: cover property (@(posedge clk) disable iff (sys_rst) $rose(overrun));
  c_tx_cycle: cover property (@(posedge clk) disable iff (sys_rst)
    ch1_tx_start ##[1:50] ch1_tx_done);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));

endmodule

// [sci_pkg.sv]
package sci_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PRIO_A = 16'hff20;
  localparam logic [15:0] IDX_PRIO_B = 16'hff21;
  localparam logic [15:0] IDX_IRQ_EN = 16'hff23;
  localparam logic [15:0] IDX_IRQ_FLAG = 16'hff27;
  localparam logic [15:0] IDX_CH1_MODE = 16'hff4c;
  localparam logic [15:0] IDX_CH1_CTRL = 16'hff4d;
  localparam logic [15:0] IDX_CH1_DATA = 16'hff4e;
  localparam logic [15:0] IDX_CH1_LINE = 16'hff4f;
  localparam logic [15:0] IDX_EVT_STATUS = 16'hff60;
  localparam logic [15:0] IDX_EVT_MASK = 16'hff61;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OVR = 4;
  localparam int CTRL_RXTRG = 3;
  localparam int CTRL_RXEN = 2;
  localparam int CTRL_TXTRG = 1;
  localparam int CTRL_TXEN = 0;
  localparam int LINE_OUT_INV = 7;
  localparam int LINE_IN_INV = 6;
  localparam int LINE_IR_EN = 4;
  localparam int LINE_STOP = 1;
  localparam int LINE_ORDER = 0;
  localparam int MODE_PIN_EN = 0;
  localparam int PRIO_CH0_LSB = 4;
  localparam int PRIO_CH1_LSB = 0;
  localparam int FLAG_ERR1 = 5;
  localparam int FLAG_REC1 = 4;
  localparam int FLAG_TRA1 = 3;
  localparam int FLAG_ERR0 = 2;
  localparam int FLAG_REC0 = 1;
  localparam int FLAG_TRA0 = 0;
  localparam int FLAG_W = 6;
  localparam int EVT_OVR = 2;
  localparam int EVT_RX = 1;
  localparam int EVT_TX = 0;
  localparam int EVT_W = 3;

  // ----------------------------------------------------------------
  // writable masks, reset values, responses
  // ----------------------------------------------------------------
  localparam logic [7:0] PRIO_A_MASK = 8'hff;
  localparam logic [7:0] PRIO_B_MASK = 8'h3f;
  localparam logic [7:0] LINE_MASK = 8'hd3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_NONE, REG_PRIO_A, REG_PRIO_B, REG_IRQ_EN, REG_IRQ_FLAG, REG_CH1_MODE,
    REG_CH1_CTRL, REG_CH1_DATA, REG_CH1_LINE, REG_EVT_STATUS, REG_EVT_MASK
  } sci_reg_type;

endpackage

// [sci_sticky_flags.sv]
`timescale 1ns/100ps
module sci_sticky_flags #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clear,
  output logic [W-1:0] flags
);

  // ----------------------------------------------------------------
  // set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clear) | set;
    end
  end

endmodule

// [sci_line_io.sv]
`timescale 1ns/100ps
module sci_line_io (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_function_enable,
  input wire logic infrared_enable,
  input wire logic input_invert,
  input wire logic output_invert,
  input wire logic [3:0] ser_out,
  input wire logic [3:0] ser_oe,
  output logic [3:0] ser_in,
  input wire logic [3:0] port_out,
  input wire logic [3:0] port_oe,
  output logic [3:0] port_in,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);

  // ----------------------------------------------------------------
  // pin order: 0 serial in, 1 serial out, 2 clock, 3 ready
  // ----------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // input inversion applies only to infrared decoding
  always_comb begin
    port_in = pin_sync;
    ser_in = pin_sync;
    ser_in[0] = pin_sync[0] ^ (infrared_enable & input_invert); // RULE_08
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
    end else if (pin_function_enable) begin // RULE_16
      pin_out <= ser_out;
      pin_out[1] <= ser_out[1] ^ (infrared_enable & output_invert); // RULE_07
      pin_oe <= ser_oe;
    end else begin
      pin_out <= port_out;
      pin_oe <= port_oe;
    end
  end

endmodule

// [sci_engine_model.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// serial engine stand-in: ends frames after DLY cycles
// ------------------------------------------------
module sci_engine_model #(
  parameter int DLY = 12,
  parameter logic [7:0] RXB = 8'h5a
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tx_start,
  input wire logic rx_start,
  input wire logic rx_poke,
  output logic tx_done,
  output logic rx_done,
  output logic [7:0] rx_byte
);
  int tx_cnt;
  int rx_cnt;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_cnt <= 0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (tx_cnt == 1);
      tx_cnt <= tx_start ? DLY : (tx_cnt != 0 ? tx_cnt - 1 : 0);
    end
  end
  // byte is valid only with the done pulse, scrambled otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_cnt <= 0;
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_done <= (rx_cnt == 1);
      rx_byte <= (rx_cnt == 1) ? RXB : ~rx_byte;
      rx_cnt <= (rx_start || rx_poke) ? DLY : (rx_cnt != 0 ? rx_cnt - 1 : 0);
    end
  end
endmodule

// [serial_ch1_ctrl_and_irq_regs_test.sv]
`timescale 1ns/100ps
module serial_ch1_ctrl_and_irq_regs_test;
  // ------------------------------------------------
  // signals and instances
  // ------------------------------------------------
  logic clk = 0, sys_rst = 1, hold = 0, rx_poke = 0, ch1_async_mode = 0, ch0_tx_done = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, ch0_irq_level, ch1_irq_level;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ch1_rx_done, ch1_tx_done, ch1_tx_start, ch1_rx_start;
  logic ch0_irq_req, ch1_irq_req, irq, ch1_infrared_enable, ch1_stop_bit_select;
  logic ch1_bit_order_select;
  logic [7:0] ch1_rx_byte, ch1_tx_byte, v;
  logic [3:0] ser_out = 0, ser_oe = 0, port_out = 0, port_oe = 0, pin_in = 0, pin_out, pin_oe;
  logic [15:0] rst_idx [8] = '{sci_pkg::IDX_PRIO_A, sci_pkg::IDX_PRIO_B, sci_pkg::IDX_IRQ_EN,
    sci_pkg::IDX_IRQ_FLAG, sci_pkg::IDX_CH1_MODE, sci_pkg::IDX_CH1_CTRL,
    sci_pkg::IDX_CH1_LINE, sci_pkg::IDX_EVT_MASK};
  int seed = 11, num_errors = 0, total_checks = 0, cycles = 0;
  always #10 clk = ~clk;
  sci_ch1_regs dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch1_async_mode,
    .ch1_rx_done, .ch1_rx_byte, .ch1_tx_done, .ch1_line_error(1'b0), .ch0_rx_done(1'b0),
    .ch0_tx_done, .ch0_line_error(1'b0), .ch1_tx_byte, .ch1_tx_start, .ch1_rx_start,
    .ch1_receive_enable(), .ch1_transmit_enable(), .ch1_receive_trigger(),
    .ch1_transmit_trigger(), .ch1_stop_bit_select, .ch1_bit_order_select,
    .ch1_infrared_enable, .serial_pin_function_enable(), .ch0_irq_level, .ch1_irq_level,
    .ch0_irq_req, .ch1_irq_req, .irq, .ser_out, .ser_oe, .ser_in(), .port_out, .port_oe,
    .port_in(), .pin_in, .pin_out, .pin_oe);
  sci_engine_model eng_u (.clk, .sys_rst, .tx_start(ch1_tx_start), .rx_start(ch1_rx_start),
    .rx_poke, .tx_done(ch1_tx_done), .rx_done(ch1_rx_done), .rx_byte(ch1_rx_byte));
  always @(posedge clk) if (!hold) {ser_out, ser_oe, port_out, port_oe, pin_in} <= 20'($random(seed));
  // ------------------------------------------------
  // bus tasks and checks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do @(posedge clk); while (s_axi_awready !== 1);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(posedge clk); while (s_axi_bvalid !== 1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
    @(posedge clk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (s_axi_rvalid !== 1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, {24'h0, e});
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task automatic wait_rx;
    do @(posedge clk); while (ch1_rx_done !== 1);
    repeat (2) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    foreach (rst_idx[i]) rd(rst_idx[i], 8'h00);
    $display("test reset values done");
    repeat (4) begin
      v = 8'($random(seed));
      wr(sci_pkg::IDX_CH1_LINE, v);
      rd(sci_pkg::IDX_CH1_LINE, v & sci_pkg::LINE_MASK);
      chk(32'({ch1_infrared_enable, ch1_stop_bit_select, ch1_bit_order_select}), 32'({v[4], v[1:0]}));
      wr(sci_pkg::IDX_PRIO_A, v);
      wr(sci_pkg::IDX_PRIO_B, ~v);
      rd(sci_pkg::IDX_PRIO_B, ~v & sci_pkg::PRIO_B_MASK);
      chk(32'({ch0_irq_level, ch1_irq_level}), 32'({v[5:4], ~v[1:0]}));
    end
    wr(sci_pkg::IDX_CH1_MODE, 8'h01);
    wr(sci_pkg::IDX_CH1_LINE, 8'h90);
    hold <= 1;
    repeat (4) @(posedge clk);
    chk(32'({pin_out[1], pin_oe}), 32'({!ser_out[1], ser_oe}));
    hold <= 0;
    $display("test options and priority done");
    wr(sci_pkg::IDX_EVT_MASK, 8'h07);
    wr(sci_pkg::IDX_IRQ_EN, 8'h08);
    wr(sci_pkg::IDX_CH1_CTRL, 8'h01);
    wr(sci_pkg::IDX_CH1_DATA, v);
    wr(sci_pkg::IDX_CH1_CTRL, 8'h03);
    rd(sci_pkg::IDX_CH1_CTRL, 8'h03);
    do @(posedge clk); while (ch1_tx_done !== 1);
    repeat (2) @(posedge clk);
    chk(32'({irq, ch1_irq_req, ch1_tx_byte}), 32'({2'b11, v}));
    rd(sci_pkg::IDX_CH1_CTRL, 8'h01);
    rd(sci_pkg::IDX_EVT_STATUS, 8'h01);
    rd(sci_pkg::IDX_IRQ_FLAG, 8'h08);
    wr(sci_pkg::IDX_IRQ_FLAG, 8'h08);
    chk(32'({irq, ch1_irq_req}), 32'h0);
    rd(sci_pkg::IDX_IRQ_FLAG, 8'h00);
    $display("test transmit done");
    ch1_async_mode <= 1;
    wr(sci_pkg::IDX_CH1_CTRL, 8'h04);
    wr(sci_pkg::IDX_CH1_CTRL, 8'h0c);
    rd(sci_pkg::IDX_CH1_CTRL, 8'h0c);
    wait_rx;
    rd(sci_pkg::IDX_CH1_DATA, 8'h5a);
    rd(sci_pkg::IDX_CH1_CTRL, 8'h04);
    rx_poke <= 1;
    @(posedge clk);
    rx_poke <= 0;
    wait_rx;
    rd(sci_pkg::IDX_CH1_CTRL, 8'h14);
    wr(sci_pkg::IDX_CH1_CTRL, 8'h04);
    rd(sci_pkg::IDX_CH1_CTRL, 8'h14);
    wr(sci_pkg::IDX_CH1_CTRL, 8'h14);
    rd(sci_pkg::IDX_CH1_CTRL, 8'h04);
    ch0_tx_done <= 1;
    @(posedge clk);
    ch0_tx_done <= 0;
    rd(sci_pkg::IDX_IRQ_FLAG, 8'h31);
    rd(16'hff22, 8'h00, sci_pkg::RESP_SLVERR);
    $display("test receive and errors done");
    wrap_up;
  end
endmodule
